// ==== src/gp_timer.sv ====
// General-purpose 32-bit timer with capture, AXI4-Lite register slave
`timescale 1ns/100ps
`include "timer_map.svh"
module gp_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic osc_clock_input,
  input wire logic gpio_clock_input_a,
  input wire logic gpio_clock_input_b,
  input wire logic low_power,
  input wire logic [31:0] irq_sources,
  output logic irq
);
  import timer_pkg::*;

  timer_ctrl_t ctrl_reg;
  logic [31:0] reload_reg;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] captured_reg;
  logic [`TMR_IRQ_W-1:0] status_reg;
  logic [`TMR_IRQ_W-1:0] mask_reg;
  logic [`TMR_PRESC_W-1:0] presc_cnt_reg;
  logic [`TMR_PRESC_W-1:0] presc_limit;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic irq_reg;
  logic aw_held_reg;
  logic [31:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic clr_fire;
  logic osc_rise;
  logic gpio_a_rise;
  logic gpio_b_rise;
  logic [31:0] irq_rise;
  logic src_tick;
  logic run_tick;
  logic count_tick;
  logic ovf;
  logic cap_evt;
  logic [31:0] wmask;
  logic [`TMR_IRQ_W-1:0] status_clr;
  logic [`TMR_IRQ_W-1:0] status_set;

  // Edge detectors for the clock sources and the capture sources
  rise_detect #(.WIDTH(1)) u_osc_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(osc_clock_input),
    .rise(osc_rise)
  );
  rise_detect #(.WIDTH(1)) u_gpio_a_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(gpio_clock_input_a),
    .rise(gpio_a_rise)
  );
  rise_detect #(.WIDTH(1)) u_gpio_b_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(gpio_clock_input_b),
    .rise(gpio_b_rise)
  );
  rise_detect #(.WIDTH(32)) u_irq_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .level(irq_sources),
    .rise(irq_rise)
  );

  // One step of the time format count; msb of result is the overflow
  function automatic logic [32:0] step_hms(input hms_t v, input logic up,
                                           input logic [7:0] hmax);
    hms_t n;
    logic o;
    n = v;
    o = 1'b0;
    if (up) begin
      if (v.hundredths != `TMR_HUND_MAX) begin
        n.hundredths = 8'(v.hundredths + 8'h01);
      end else begin
        n.hundredths = 8'h00;
        if (v.seconds != `TMR_MINSEC_MAX) begin
          n.seconds = 8'(v.seconds + 8'h01);
        end else begin
          n.seconds = 8'h00;
          if (v.minutes != `TMR_MINSEC_MAX) begin
            n.minutes = 8'(v.minutes + 8'h01);
          end else begin
            n.minutes = 8'h00;
            if (v.hours != hmax) begin
              n.hours = 8'(v.hours + 8'h01);
            end else begin
              n.hours = 8'h00;
              o = 1'b1;
            end
          end
        end
      end
    end else begin
      if (v.hundredths != 8'h00) begin
        n.hundredths = 8'(v.hundredths - 8'h01);
      end else begin
        n.hundredths = `TMR_HUND_MAX;
        if (v.seconds != 8'h00) begin
          n.seconds = 8'(v.seconds - 8'h01);
        end else begin
          n.seconds = `TMR_MINSEC_MAX;
          if (v.minutes != 8'h00) begin
            n.minutes = 8'(v.minutes - 8'h01);
          end else begin
            n.minutes = `TMR_MINSEC_MAX;
            if (v.hours != 8'h00) begin
              n.hours = 8'(v.hours - 8'h01);
            end else begin
              n.hours = hmax;
              o = 1'b1;
            end
          end
        end
      end
    end
    return {o, n};
  endfunction

  // Bus handshakes and register write strobes
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign clr_fire = wr_fire && (aw_addr_reg == `TMR_CLEAR_ADDR); // [R8]
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}},
                  {8{w_strb_reg[0]}}};

  // Source selection; core clock halts in low power [R2] [R12]
  always_comb begin
    case (ctrl_reg.src)
      SRC_CORE: src_tick = !low_power;
      SRC_OSC: src_tick = osc_rise;
      SRC_GPIO_A: src_tick = gpio_a_rise;
      SRC_GPIO_B: src_tick = gpio_b_rise;
      default: src_tick = 1'b0;
    endcase
  end

  // Divide by two to the power of the prescaler code [R3]
  assign presc_limit = `TMR_PRESC_W'((32'h1 << ctrl_reg.presc) - 32'h1);
  assign run_tick = ctrl_reg.enable && src_tick; // [R10]
  assign count_tick = run_tick && (presc_cnt_reg == presc_limit); // [R1]

  // Prescaler counter, restarted by a clear write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt_reg <= '0;
    end else if (clr_fire || count_tick) begin
      presc_cnt_reg <= '0;
    end else if (run_tick) begin
      presc_cnt_reg <= `TMR_PRESC_W'(presc_cnt_reg + `TMR_PRESC_W'(1));
    end
  end

  // Next count and overflow for the chosen format and direction [R4] [R9]
  always_comb begin
    logic [32:0] h;
    h = 33'h0;
    case (ctrl_reg.fmt)
      FMT_HMS_23: begin
        h = step_hms(hms_t'(count_reg), ctrl_reg.count_up, `TMR_HOURS_SHORT); // [R16]
        count_next = h[31:0];
        ovf = h[32];
      end
      FMT_HMS_255: begin
        h = step_hms(hms_t'(count_reg), ctrl_reg.count_up, `TMR_HOURS_LONG); // [R16]
        count_next = h[31:0];
        ovf = h[32];
      end
      default: begin
        if (ctrl_reg.count_up) begin
          count_next = 32'(count_reg + 32'h1);
          ovf = (count_reg == 32'hffff_ffff);
        end else begin
          count_next = 32'(count_reg - 32'h1);
          ovf = (count_reg == 32'h0);
        end
      end
    endcase
  end

  // Counter: clear write reloads, periodic reloads, free-running wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= `TMR_COUNT_RST;
    end else if (clr_fire) begin
      count_reg <= reload_reg; // [R7] [R8]
    end else if (count_tick) begin
      if (ovf && ctrl_reg.periodic) begin
        count_reg <= reload_reg; // [R7] [R11]
      end else begin
        count_reg <= count_next; // [R15]
      end
    end
  end

  // Capture on every rise of the chosen source while capture is enabled [R5] [R6]
  assign cap_evt = ctrl_reg.cap_en && irq_rise[ctrl_reg.cap_sel];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      captured_reg <= `TMR_CAPTURE_RST;
    end else if (cap_evt) begin
      captured_reg <= count_reg; // [R5]
    end
  end

  // Status clear: W1C on lane 0, clear write drops the overflow bit [R8]
  assign status_clr = ((wr_fire && aw_addr_reg == `TMR_STATUS_ADDR && w_strb_reg[0])
                       ? w_data_reg[`TMR_IRQ_W-1:0] : `TMR_IRQ_W'(0))
                      | `TMR_IRQ_W'(clr_fire);
  assign status_set = {cap_evt, count_tick && ovf}; // Bit 1 capture, bit 0 overflow [R15]

  // Sticky status; an event in the clearing cycle stays set [R15] [R8]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= `TMR_IRQ_RST;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
    end
  end

  // Interrupt line from the masked status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // Software-written registers; reserved control bits are not stored [R14]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_reg <= `TMR_RELOAD_RST;
      ctrl_reg <= timer_ctrl_t'(`TMR_CTRL_RST);
      mask_reg <= `TMR_IRQ_RST;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        `TMR_RELOAD_ADDR: reload_reg <= (reload_reg & ~wmask) | (w_data_reg & wmask);
        `TMR_CTRL_ADDR: begin
          ctrl_reg <= timer_ctrl_t'(`TMR_CTRL_W'((32'(ctrl_reg) & ~wmask)
                                                 | (w_data_reg & wmask)));
        end
        `TMR_MASK_ADDR: begin
          if (w_strb_reg[0]) begin
            mask_reg <= w_data_reg[`TMR_IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 32'h0;
    end else if (awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (!aw_held_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (!w_held_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // Write response; unmapped address answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `TMR_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      case (aw_addr_reg)
        `TMR_RELOAD_ADDR, `TMR_COUNT_ADDR, `TMR_CTRL_ADDR, `TMR_CLEAR_ADDR,
        `TMR_CAPTURE_ADDR, `TMR_STATUS_ADDR, `TMR_MASK_ADDR: bresp_reg <= `TMR_RESP_OKAY;
        default: bresp_reg <= `TMR_RESP_SLVERR;
      endcase
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; live count and capture are read-only views [R13]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `TMR_RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= `TMR_RESP_OKAY;
      case (araddr)
        `TMR_RELOAD_ADDR: rdata_reg <= reload_reg;
        `TMR_COUNT_ADDR: rdata_reg <= count_reg; // [R13]
        `TMR_CTRL_ADDR: rdata_reg <= 32'(ctrl_reg);
        `TMR_CLEAR_ADDR: rdata_reg <= 32'h0;
        `TMR_CAPTURE_ADDR: rdata_reg <= captured_reg; // [R13]
        `TMR_STATUS_ADDR: rdata_reg <= 32'(status_reg);
        `TMR_MASK_ADDR: rdata_reg <= 32'(mask_reg);
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= `TMR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // Outputs
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq = irq_reg;

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_clear_write;
    clr_fire && !(count_tick && ovf);
  endsequence

  sequence s_down_tick;
    count_tick && !ctrl_reg.count_up && ctrl_reg.fmt == FMT_BINARY;
  endsequence

  AST_CLEAR_RELOADS: assert property (clr_fire |=> count_reg == $past(reload_reg)) // [R7]
    else $error("clear write did not reload counter");
  AST_CLEAR_IRQ: assert property (s_clear_write ##1 1'b1 |-> !status_reg[0]) // [R8]
    else $error("clear write left timer interrupt set");
  AST_STOPPED_HOLDS: assert property (!ctrl_reg.enable && !clr_fire // [R10]
    |=> $stable(count_reg))
    else $error("disabled counter changed");
  AST_CAPTURE_COPY: assert property (cap_evt |=> captured_reg == $past(count_reg)) // [R5]
    else $error("capture did not copy count");
  AST_CAPTURE_OFF: assert property (!ctrl_reg.cap_en |=> $stable(captured_reg)) // [R6]
    else $error("capture changed while disabled");
  AST_COUNT_DOWN: assert property ((s_down_tick and (count_reg != 32'h0 && !clr_fire)) // [R9]
    |=> count_reg == 32'($past(count_reg) - 32'h1))
    else $error("down count step wrong");
  AST_COUNT_UP: assert property (count_tick && ctrl_reg.count_up // [R1]
    && ctrl_reg.fmt == FMT_BINARY && !ovf && !clr_fire
    |=> count_reg == 32'($past(count_reg) + 32'h1))
    else $error("up count step wrong");
  AST_PERIODIC_RELOAD: assert property ((s_down_tick and (count_reg == 32'h0 // [R11]
    && ctrl_reg.periodic && !clr_fire)) |=> count_reg == $past(reload_reg))
    else $error("periodic overflow did not reload");
  AST_FREE_WRAP: assert property ((s_down_tick and (count_reg == 32'h0 // [R15]
    && !ctrl_reg.periodic && !clr_fire)) |=> count_reg == 32'hffff_ffff && status_reg[0])
    else $error("free-running underflow did not wrap");
  AST_LOW_POWER_CORE: assert property (low_power && ctrl_reg.src == SRC_CORE // [R12]
    |-> !count_tick)
    else $error("core-clocked counter ran in low power");
  AST_HMS_CARRY: assert property (count_tick && ctrl_reg.fmt[1] && ctrl_reg.count_up // [R16]
    && count_reg[7:0] == `TMR_HUND_MAX && !clr_fire |=> count_reg[7:0] == 8'h00)
    else $error("hundredths did not roll over");
  AST_IRQ_LEVEL: assert property (##1 irq == $past(|(status_reg & mask_reg)))
    else $error("interrupt line disagrees with masked status");

endmodule

// ==== pkg/timer_map.svh ====
// Register map, field positions and constants of the general-purpose timer
// How it works
// (R1) 32-bit counter counts down or up, through a programmable prescaler.
// (R2) Control bits 11:9 pick clock: core, oscillator, GPIO input a, GPIO input b.
// (R3) Control bits 3:0 divide source by 2 to the power of the code.
// (R4) Control bits 5:4: binary, reserved, H:M:S:hundredths to 23 or 255 hours.
// (R5) On first rise of chosen interrupt source, copy count; counter keeps running. Code copies the count on every rise.
// (R6) Control bit 17 enables capture; bits 16:12 choose source 0 to 31.
// (R7) Counter reloads from reload register on overflow and on clear write. Code reloads on overflow only in periodic mode; free-running wraps.
// (R8) Any write to clear register clears timer interrupt and reloads counter.
// (R9) Control bit 8 set counts up, clear counts down; down after reset.
// (R10) Control bit 7 enables counting; resets to zero, timer stopped.
// (R11) Control bit 6 set is periodic, clear is free-running; free after reset.
// (R12) In low power the counter runs only from oscillator or GPIO source.
// (R13) Live count and last captured count readable as 32-bit read-only registers.
// (R14) Software writes zeros to reserved control bits 31:18.
// (R15) Free-running wraps on overflow; every overflow or underflow raises interrupt.
// (R16) Time format fields roll at 100 hundredths, 60 seconds, 60 minutes.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Register byte addresses
`define TMR_RELOAD_ADDR 32'hffff0380
`define TMR_COUNT_ADDR 32'hffff0384
`define TMR_CTRL_ADDR 32'hffff0388
`define TMR_CLEAR_ADDR 32'hffff038c
`define TMR_CAPTURE_ADDR 32'hffff0390
`define TMR_STATUS_ADDR 32'hffff0394
`define TMR_MASK_ADDR 32'hffff0398

// Reset values
`define TMR_RELOAD_RST 32'h0000_0000
`define TMR_COUNT_RST 32'h0000_0000
`define TMR_CAPTURE_RST 32'h0000_0000
`define TMR_CTRL_RST 18'h0_0000
`define TMR_IRQ_RST 2'h0

// Control field layout
`define TMR_CTRL_W 18
`define TMR_CTRL_CAP_EN_BIT 17
`define TMR_CTRL_SEL_LSB 12
`define TMR_CTRL_SRC_LSB 9
`define TMR_CTRL_UP_BIT 8
`define TMR_CTRL_EN_BIT 7
`define TMR_CTRL_PER_BIT 6
`define TMR_CTRL_FMT_LSB 4
`define TMR_CTRL_PRE_LSB 0

// Interrupt status layout
`define TMR_IRQ_W 2
`define TMR_IRQ_OVF_BIT 0
`define TMR_IRQ_CAP_BIT 1

// Prescaler counter width, enough for divide by 32768
`define TMR_PRESC_W 15

// Time format limits
`define TMR_HUND_MAX 8'h63
`define TMR_MINSEC_MAX 8'h3b
`define TMR_HOURS_SHORT 8'h17
`define TMR_HOURS_LONG 8'hff

// Bus responses
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

// ==== pkg/timer_pkg.sv ====
// Types of the general-purpose timer
package timer_pkg;

  typedef enum logic [2:0] {
    SRC_CORE = 3'h0,
    SRC_OSC = 3'h1,
    SRC_GPIO_A = 3'h2,
    SRC_GPIO_B = 3'h3
  } clk_src_t;

  typedef enum logic [1:0] {
    FMT_BINARY = 2'h0,
    FMT_RESERVED = 2'h1,
    FMT_HMS_23 = 2'h2,
    FMT_HMS_255 = 2'h3
  } count_fmt_t;

  // Stored control bits 17:0, msb first
  typedef struct packed {
    logic cap_en;
    logic [4:0] cap_sel;
    clk_src_t src;
    logic count_up;
    logic enable;
    logic periodic;
    count_fmt_t fmt;
    logic [3:0] presc;
  } timer_ctrl_t;

  // Time format view of the count
  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] hundredths;
  } hms_t;

endpackage

// ==== src/rise_detect.sv ====
// Rising-edge detector for inputs synchronous to the clock
`timescale 1ns/100ps
module rise_detect #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] prev_reg;

  // Previous level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  // High for one cycle after a low-to-high change
  assign rise = level & ~prev_reg;

endmodule

// ==== testbench/gp_timer_tb.sv ====
// Self-checking testbench of the general-purpose timer
`timescale 1ns/100ps
`include "timer_map.svh"
module gp_timer_tb;
  import timer_pkg::*;
  localparam logic [31:0] LD = `TMR_RELOAD_ADDR;
  localparam logic [31:0] CNT = `TMR_COUNT_ADDR;
  localparam logic [31:0] CTL = `TMR_CTRL_ADDR;
  localparam logic [31:0] CLR = `TMR_CLEAR_ADDR;
  localparam logic [31:0] CAP = `TMR_CAPTURE_ADDR;
  localparam logic [31:0] STS = `TMR_STATUS_ADDR;
  localparam logic [31:0] MSK = `TMR_MASK_ADDR;
  localparam logic [1:0] OK = `TMR_RESP_OKAY;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, irq_sources = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic osc_clock_input = 0, gpio_clock_input_a = 0, gpio_clock_input_b = 0;
  logic low_power = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  gp_timer gp_timer_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .osc_clock_input(osc_clock_input),
    .gpio_clock_input_a(gpio_clock_input_a), .gpio_clock_input_b(gpio_clock_input_b),
    .low_power(low_power), .irq_sources(irq_sources), .irq(irq)
  );

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  // Hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      $display("MISMATCH timeout expected finish seen hang");
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write with both channels offered together, response checked
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = OK);
    logic aw;
    logic w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 0;
    chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
  endtask

  // Raw read into v
  task automatic rd(input logic [31:0] a, input logic [1:0] er = OK);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rready <= 0;
    v = rdata;
    chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = OK);
    rd(a, er);
    chk($sformatf("rdata %h", a), e, v);
  endtask

  task automatic irqchk(input logic e);
    repeat (3) @(posedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // One-cycle pulses on a tick source: 1 oscillator, 2 gpio a, 3 gpio b
  task automatic tick(input int n, input int src);
    repeat (n) begin
      @(posedge aclk);
      case (src)
        1: osc_clock_input <= 1;
        2: gpio_clock_input_a <= 1;
        default: gpio_clock_input_b <= 1;
      endcase
      @(posedge aclk);
      osc_clock_input <= 0;
      gpio_clock_input_a <= 0;
      gpio_clock_input_b <= 0;
    end
    repeat (3) @(posedge aclk);
  endtask

  // Control word built from bit positions, enable set
  function automatic logic [31:0] cw(logic [2:0] src, logic [3:0] pre, logic [1:0] fmt,
      logic up, logic per, logic cp = 0, logic [4:0] sel = 0);
    return {14'h0, cp, sel, src, up, 1'b1, per, fmt, pre};
  endfunction

  task automatic t_reset();
    rc(LD, 32'h0);
    rc(CNT, 32'h0);
    rc(CTL, 32'h0);
    rc(CAP, 32'h0);
    rc(STS, 32'h0);
    rc(MSK, 32'h0);
    irqchk(0);
  endtask

  task automatic t_regs();
    wr(LD, 32'h1234_5678);
    rc(LD, 32'h1234_5678);
    wr(CTL, 32'hfffc_0000);
    rc(CTL, 32'h0);
    wr(CNT, 32'hdead_beef);
    wr(CAP, 32'hdead_beef);
    rc(CNT, 32'h0);
    rc(CAP, 32'h0);
    rc(CLR, 32'h0);
    wr(32'hffff_03a0, 32'h1, `TMR_RESP_SLVERR);
    rc(32'hffff_03a0, 32'h0, `TMR_RESP_SLVERR);
  endtask

  task automatic t_periodic();
    wr(LD, 32'h3);
    wr(CLR, 32'h0);
    rc(CNT, 32'h3);
    wr(MSK, 32'h1);
    wr(CTL, cw(3'h2, 4'h0, 2'h0, 0, 1));
    tick(3, 2);
    rc(CNT, 32'h0);
    rc(STS, 32'h0);
    tick(1, 2);
    rc(CNT, 32'h3);
    rc(STS, 32'h1);
    irqchk(1);
    wr(MSK, 32'h0);
    irqchk(0);
    wr(MSK, 32'h1);
    irqchk(1);
    tick(1, 2);
    rc(CNT, 32'h2);
    wr(CLR, 32'h0000_00a5);
    rc(CNT, 32'h3);
    rc(STS, 32'h0);
    irqchk(0);
  endtask

  task automatic t_free();
    wr(LD, 32'h1);
    wr(CTL, cw(3'h3, 4'h0, 2'h0, 0, 0));
    wr(CLR, 32'h0);
    tick(2, 3);
    rc(CNT, 32'hffff_ffff);
    rc(STS, 32'h1);
    tick(2, 2);
    rc(CNT, 32'hffff_ffff);
    wr(STS, 32'h1);
    rc(STS, 32'h0);
    irqchk(0);
    wr(LD, 32'hffff_fffe);
    wr(CTL, cw(3'h3, 4'h0, 2'h0, 1, 0));
    wr(CLR, 32'h0);
    tick(1, 3);
    rc(CNT, 32'hffff_ffff);
    tick(1, 3);
    rc(CNT, 32'h0);
    rc(STS, 32'h1);
    wr(STS, 32'h1);
  endtask

  task automatic t_power();
    wr(LD, 32'h100);
    wr(CTL, 32'h0);
    wr(CLR, 32'h0);
    repeat (10) @(posedge aclk);
    rc(CNT, 32'h100);
    low_power <= 1;
    wr(CTL, cw(3'h0, 4'h0, 2'h0, 0, 0));
    repeat (10) @(posedge aclk);
    rc(CNT, 32'h100);
    wr(CTL, cw(3'h1, 4'h0, 2'h0, 0, 0));
    tick(2, 1);
    rc(CNT, 32'hfe);
    low_power <= 0;
    wr(CTL, cw(3'h0, 4'h0, 2'h0, 0, 0));
    rd(CNT);
    chk("core count moved", 32'h1, {31'h0, v < 32'hfe && v > 32'he0});
    wr(CTL, 32'h0);
    wr(STS, 32'h3);
  endtask

  task automatic t_presc();
    for (int c = 4; c <= 8; c += 4) begin
      wr(CTL, cw(3'h2, 4'(c), 2'h0, 0, 0) & ~32'h80);
      wr(LD, 32'h50);
      wr(CLR, 32'h0);
      wr(CTL, cw(3'h2, 4'(c), 2'h0, 0, 0));
      tick((1 << c) - 1, 2);
      rc(CNT, 32'h50);
      tick(1, 2);
      rc(CNT, 32'h4f);
    end
  endtask

  task automatic t_capture();
    wr(LD, 32'h20);
    wr(CTL, cw(3'h2, 4'h0, 2'h0, 0, 0, 1, 5'd5));
    wr(CLR, 32'h0);
    tick(3, 2);
    irq_sources <= 32'h80;
    repeat (3) @(posedge aclk);
    rc(CAP, 32'h0);
    irq_sources <= 32'ha0;
    repeat (3) @(posedge aclk);
    rc(CAP, 32'h1d);
    rc(STS, 32'h2);
    tick(1, 2);
    rc(CNT, 32'h1c);
    rc(CAP, 32'h1d);
    irq_sources <= 32'h0;
    wr(CTL, cw(3'h2, 4'h0, 2'h0, 0, 0, 0, 5'd31));
    irq_sources <= 32'h8000_0000;
    repeat (3) @(posedge aclk);
    rc(CAP, 32'h1d);
    irq_sources <= 32'h0;
    wr(CTL, cw(3'h2, 4'h0, 2'h0, 0, 0, 1, 5'd31));
    irq_sources <= 32'h8000_0000;
    repeat (3) @(posedge aclk);
    rc(CAP, 32'h1c);
    irq_sources <= 32'h0;
  endtask

  task automatic t_hms();
    logic [1:0] fm[6] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
    logic up[6] = '{1, 1, 0, 0, 0, 1};
    logic [31:0] st[6] = '{32'h3b63, 32'h173b3b63, 32'h10000, 32'h0, 32'h0, 32'hff3b3b63};
    logic [31:0] ex[6] = '{32'h10000, 32'h0, 32'h3b63, 32'h173b3b63, 32'hff3b3b63, 32'h0};
    logic [31:0] ov[6] = '{32'h0, 32'h1, 32'h0, 32'h1, 32'h1, 32'h1};
    for (int i = 0; i < 6; i++) begin
      wr(LD, st[i]);
      wr(CTL, cw(3'h2, 4'h0, fm[i], up[i], 0));
      wr(CLR, 32'h0);
      wr(STS, 32'h3);
      tick(1, 2);
      rc(CNT, ex[i]);
      rc(STS, ov[i]);
    end
    wr(LD, 32'h3b63);
    wr(CTL, cw(3'h2, 4'h0, 2'h1, 1, 0));
    wr(CLR, 32'h0);
    tick(1, 2);
    rc(CNT, 32'h3b64);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_reset();
    $display("reset test done");
    t_regs();
    $display("register test done");
    t_periodic();
    $display("periodic test done");
    t_free();
    $display("free-running test done");
    t_power();
    $display("power test done");
    t_presc();
    $display("prescaler test done");
    t_capture();
    $display("capture test done");
    t_hms();
    $display("time format test done");
    results();
  end
endmodule
